// ==== design/frt_capture.sv ====
// Capture unit: edge select on the trigger pin, latches the count
`timescale 1ns/1ps
module frt_capture (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Trigger pin and its setup
    input wire logic pin,
    input wire logic pin_is_input,
    input wire logic [1:0] edge_sel,
    // Counter to copy
    input wire logic [15:0] count,
    // Captured value
    output logic [15:0] value,
    output logic loaded
);
    frt_pkg::frt_cap_s st_ff;
    frt_pkg::frt_cap_s nxt_st;
    logic rise;
    logic fall;
    logic hit;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.pin_d = pin;
        rise = pin & ~st_ff.pin_d;
        fall = ~pin & st_ff.pin_d;
        unique case (frt_pkg::frt_edge_e'(edge_sel))
            frt_pkg::EDGE_OFF: hit = 1'b0;
            frt_pkg::EDGE_RISE: hit = rise;
            frt_pkg::EDGE_FALL: hit = fall;
            frt_pkg::EDGE_BOTH: hit = rise | fall;
        endcase
        hit = hit & pin_is_input;
        nxt_st.loaded = hit;
        if (hit)
            nxt_st.value = count;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff.pin_d <= 1'b0;
            st_ff.value <= frt_pkg::RST_CAP;
            st_ff.loaded <= 1'b0;
        end
        else
            st_ff <= nxt_st;
    end

    assign value = st_ff.value;
    assign loaded = st_ff.loaded;

    a_cap_off: assert property (
        @(posedge clk) disable iff (!rst_n)
        (edge_sel == 2'h0 || !pin_is_input) |=> !loaded)
        else $error("capture taken while disabled");

    a_cap_rise: assert property (
        @(posedge clk) disable iff (!rst_n)
        (pin_is_input && edge_sel == 2'h1 && pin && !st_ff.pin_d)
        |=> loaded && value == $past(count))
        else $error("rising edge not captured");

    a_cap_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !hit |=> $stable(value))
        else $error("capture value changed without edge");

endmodule : frt_capture

// ==== design/frt_prescaler.sv ====
// Count-clock prescaler: one-cycle tick at the selected division
`timescale 1ns/1ps
module frt_prescaler (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Division select
    input wire logic [1:0] sel,
    // Count pulse
    output logic tick
);
    frt_pkg::frt_pre_s st_ff;
    frt_pkg::frt_pre_s nxt_st;
    logic [7:0] mask;

    always_comb
    begin
        nxt_st = st_ff;
        unique case (sel)
            2'h0: mask = frt_pkg::DIV2_MASK;
            2'h1: mask = frt_pkg::DIV4_MASK;
            2'h2: mask = frt_pkg::DIV16_MASK;
            2'h3: mask = frt_pkg::DIV256_MASK;
        endcase
        nxt_st.div = st_ff.div + 8'h01;
        nxt_st.tick = ((st_ff.div & mask) == mask);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign tick = st_ff.tick;

    a_div2_alt: assert property (
        @(posedge clk) disable iff (!rst_n)
        (sel == 2'h0 && $stable(sel) && tick) |=> !tick)
        else $error("divide-by-two tick not alternating");

    a_div4_gap: assert property (
        @(posedge clk) disable iff (!rst_n)
        (sel == 2'h1 && $stable(sel) && tick) ##1 (sel == 2'h1)
        |-> !tick ##1 !tick)
        else $error("divide-by-four tick too frequent");

endmodule : frt_prescaler

// ==== design/frt_timer.sv ====
// Free-running 16-bit timer with compare, capture and read buffer
`timescale 1ns/1ps
module frt_timer (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // CPU memory access
    input wire logic [15:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic WIDE,
    input wire logic [15:0] WDATA,
    input wire logic [7:0] WMASK,
    output logic [15:0] RDATA,
    output logic RVALID,
    // Trigger pin
    input wire logic CAPTURE_PIN,
    // Interrupt request and port 2 buffers
    output logic COMPARE_IRQ,
    output logic [7:0] PORT2_OE_N
);
    logic rst_meta_ff;
    logic rst_n_ff;
    frt_pkg::frt_main_s st_ff;
    frt_pkg::frt_main_s nxt_st;
    logic tick;
    logic [15:0] cap_value;
    logic cap_loaded;
    logic ovf;
    logic [7:0] wmask_eff;
    logic [7:0] whi_data;

    function automatic logic [7:0] merge8(
        input logic [7:0] old_v,
        input logic [7:0] new_v,
        input logic [7:0] mask
    );
        merge8 = (old_v & ~mask) | (new_v & mask);
    endfunction : merge8

    function automatic logic hit_hi(
        input logic [15:0] addr,
        input logic wide,
        input logic [15:0] base
    );
        hit_hi = wide ? (addr == base)
                      : (addr == base + frt_pkg::ADDR_HI_OFS);
    endfunction : hit_hi

    // Reset release through two flops
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    frt_prescaler u_pre (
        .clk(SYS_CLK),
        .rst_n(rst_n_ff),
        .sel(st_ff.mode[frt_pkg::MODE_TCL_LSB +: 2]),
        .tick(tick)
    );

    frt_capture u_cap (
        .clk(SYS_CLK),
        .rst_n(rst_n_ff),
        .pin(CAPTURE_PIN),
        .pin_is_input(st_ff.dir[frt_pkg::DIR_CAP_BIT]),
        .edge_sel(st_ff.mode[frt_pkg::MODE_CPT_LSB +: 2]),
        .count(st_ff.cnt),
        .value(cap_value),
        .loaded(cap_loaded)
    );

    always_comb
    begin
        nxt_st = st_ff;
        wmask_eff = WIDE ? 8'hff : WMASK;
        whi_data = WIDE ? WDATA[15:8] : WDATA[7:0];

        // no stop gating on the count
        if (tick)
            nxt_st.cnt = st_ff.cnt + frt_pkg::CNT_STEP;
        ovf = tick && (st_ff.cnt == frt_pkg::CNT_MAX);

        if (WR_EN && ADDR == frt_pkg::ADDR_CMP)
            nxt_st.cmp[7:0] = merge8(st_ff.cmp[7:0], WDATA[7:0], wmask_eff);
        if (WR_EN && hit_hi(ADDR, WIDE, frt_pkg::ADDR_CMP))
            nxt_st.cmp[15:8] = merge8(st_ff.cmp[15:8], whi_data, wmask_eff);

        // bit or byte writes to mode
        if (WR_EN && !WIDE && ADDR == frt_pkg::ADDR_MODE)
        begin
            nxt_st.mode = merge8(st_ff.mode, WDATA[7:0],
                                 WMASK & frt_pkg::MODE_WMASK);
            // software clears flag by writing zero
            nxt_st.mode[frt_pkg::MODE_TOF_BIT] =
                st_ff.mode[frt_pkg::MODE_TOF_BIT]
                & ~(WMASK[frt_pkg::MODE_TOF_BIT]
                    & ~WDATA[frt_pkg::MODE_TOF_BIT]);
        end
        if (ovf)
            nxt_st.mode[frt_pkg::MODE_TOF_BIT] = 1'b1;

        if (WR_EN && !WIDE && ADDR == frt_pkg::ADDR_DIR)
            nxt_st.dir = merge8(st_ff.dir, WDATA[7:0], WMASK);

        // buffer follows the count until frozen
        if (!st_ff.held)
            nxt_st.rbuf = st_ff.cnt;

        nxt_st.irq = (st_ff.cnt == st_ff.cmp);

        nxt_st.rvalid = RD_EN;
        if (RD_EN)
        begin
            unique case (ADDR)
                frt_pkg::ADDR_CMP:
                    nxt_st.rdata = WIDE ? st_ff.cmp : {8'h00, st_ff.cmp[7:0]};
                frt_pkg::ADDR_CMP + frt_pkg::ADDR_HI_OFS:
                    nxt_st.rdata = {8'h00, WIDE ? 8'h00 : st_ff.cmp[15:8]};
                frt_pkg::ADDR_CAP:
                    nxt_st.rdata = WIDE ? cap_value : {8'h00, cap_value[7:0]};
                frt_pkg::ADDR_CAP + frt_pkg::ADDR_HI_OFS:
                    nxt_st.rdata = {8'h00, WIDE ? 8'h00 : cap_value[15:8]};
                frt_pkg::ADDR_CNT:
                begin
                    if (WIDE)
                        nxt_st.rdata = st_ff.cnt;
                    else
                    begin
                        nxt_st.rdata = {8'h00, st_ff.cnt[7:0]};
                        nxt_st.rbuf = st_ff.cnt;
                        nxt_st.held = 1'b1;
                    end
                end
                frt_pkg::ADDR_CNT + frt_pkg::ADDR_HI_OFS:
                begin
                    if (WIDE)
                        nxt_st.rdata = 16'h0000;
                    else
                    begin
                        nxt_st.rdata = {8'h00, st_ff.held ? st_ff.rbuf[15:8]
                                                          : st_ff.cnt[15:8]};
                        nxt_st.held = 1'b0;
                    end
                end
                frt_pkg::ADDR_MODE:
                    nxt_st.rdata = {8'h00, st_ff.mode};
                frt_pkg::ADDR_DIR:
                    nxt_st.rdata = {8'h00, st_ff.dir};
                default:
                    nxt_st.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            st_ff <= frt_pkg::MAIN_RST;
        else
            st_ff <= nxt_st;
    end

    assign RDATA = st_ff.rdata;
    assign RVALID = st_ff.rvalid;
    assign COMPARE_IRQ = st_ff.irq;
    assign PORT2_OE_N = st_ff.dir;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!rst_n_ff);

    a_cnt_step: assert property (
        tick |=> st_ff.cnt == $past(st_ff.cnt) + frt_pkg::CNT_STEP)
        else $error("counter did not advance on tick");

    a_cnt_idle: assert property (
        !tick |=> $stable(st_ff.cnt))
        else $error("counter moved without tick");

    a_irq_match: assert property (
        (st_ff.cnt == st_ff.cmp) |=> COMPARE_IRQ)
        else $error("match did not raise request");

    a_irq_nomatch: assert property (
        (st_ff.cnt != st_ff.cmp) |=> !COMPARE_IRQ)
        else $error("request without match");

    a_cmp_word: assert property (
        (WR_EN && WIDE && ADDR == frt_pkg::ADDR_CMP)
        |=> st_ff.cmp == $past(WDATA))
        else $error("compare word write lost");

    a_cmp_hi_byte: assert property (
        (WR_EN && !WIDE && WMASK == 8'hff
         && ADDR == frt_pkg::ADDR_CMP + frt_pkg::ADDR_HI_OFS)
        |=> st_ff.cmp[15:8] == $past(WDATA[7:0])
            && st_ff.cmp[7:0] == $past(st_ff.cmp[7:0]))
        else $error("compare high byte write wrong");

    a_rbuf_hold: assert property (
        (st_ff.held && !RD_EN) |=> $stable(st_ff.rbuf) && st_ff.held)
        else $error("frozen read buffer changed");

    a_pair_read: assert property (
        (RD_EN && !WIDE && ADDR == frt_pkg::ADDR_CNT)
        ##1 (RD_EN && !WIDE
             && ADDR == frt_pkg::ADDR_CNT + frt_pkg::ADDR_HI_OFS)
        |=> RDATA[7:0] == $past(st_ff.rbuf[15:8]) && !st_ff.held)
        else $error("paired counter read inconsistent");

    a_tof_set: assert property (
        (tick && st_ff.cnt == frt_pkg::CNT_MAX)
        |=> st_ff.mode[frt_pkg::MODE_TOF_BIT] && st_ff.cnt == frt_pkg::RST_CNT)
        else $error("overflow flag not set on wrap");

    a_no_clear: assert property (
        (st_ff.cnt == st_ff.cmp && tick && st_ff.cnt != frt_pkg::CNT_MAX)
        |=> st_ff.cnt != frt_pkg::RST_CNT)
        else $error("counter cleared on match");

    a_cap_copy: assert property (
        cap_loaded |-> cap_value == $past(st_ff.cnt))
        else $error("capture value is not the counter");

    a_rd_answer: assert property (
        RD_EN |=> RVALID ##1 (RVALID == $past(RD_EN)))
        else $error("read not answered next cycle");

    a_rvalid_idle: assert property (
        !RD_EN |=> !RVALID)
        else $error("read answer without request");

    a_tof_clear: assert property (
        (WR_EN && !WIDE && ADDR == frt_pkg::ADDR_MODE && !ovf
         && WMASK[frt_pkg::MODE_TOF_BIT] && !WDATA[frt_pkg::MODE_TOF_BIT])
        |=> !st_ff.mode[frt_pkg::MODE_TOF_BIT])
        else $error("overflow flag not cleared by write");

    a_tof_sticky: assert property (
        (st_ff.mode[frt_pkg::MODE_TOF_BIT]
         && !(WR_EN && !WIDE && ADDR == frt_pkg::ADDR_MODE))
        |=> st_ff.mode[frt_pkg::MODE_TOF_BIT])
        else $error("overflow flag dropped without write");

    a_mode_zero: assert property (
        (st_ff.mode & ~frt_pkg::MODE_WMASK
         & ~(8'h01 << frt_pkg::MODE_TOF_BIT)) == 8'h00)
        else $error("fixed mode bits not zero");

    a_dir_byte: assert property (
        (WR_EN && !WIDE && ADDR == frt_pkg::ADDR_DIR && WMASK == 8'hff)
        |=> PORT2_OE_N == $past(WDATA[7:0]))
        else $error("direction byte write lost");

    a_cnt_word: assert property (
        (RD_EN && WIDE && ADDR == frt_pkg::ADDR_CNT)
        |=> RDATA == $past(st_ff.cnt))
        else $error("counter word read wrong");

    a_cmp_odd_word: assert property (
        (WR_EN && WIDE && ADDR == frt_pkg::ADDR_CMP + frt_pkg::ADDR_HI_OFS)
        |=> $stable(st_ff.cmp))
        else $error("odd word write changed compare");

endmodule : frt_timer

// ==== include/frt_pkg.sv ====
// Constants and types shared by the free-running timer design
package frt_pkg;

    // Register byte addresses (16-bit registers: low byte, high at +1)
    localparam logic [15:0] ADDR_CMP = 16'hff16;
    localparam logic [15:0] ADDR_CNT = 16'hff18;
    localparam logic [15:0] ADDR_CAP = 16'hff1a;
    localparam logic [15:0] ADDR_MODE = 16'hff48;
    localparam logic [15:0] ADDR_DIR = 16'hff22;
    localparam logic [15:0] ADDR_HI_OFS = 16'h0001;

    // Reset values, counter maximum and count step
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [15:0] RST_CMP = 16'hffff;
    localparam logic [15:0] RST_CAP = 16'h0000;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_STEP = 16'h0001;

    // Mode register layout; bits 0, 3 and 7 are fixed at zero
    localparam int MODE_TCL_LSB = 1;
    localparam int MODE_CPT_LSB = 4;
    localparam int MODE_TOF_BIT = 6;
    localparam logic [7:0] MODE_WMASK = 8'h36;

    // Trigger pin direction bit in the port direction register
    localparam int DIR_CAP_BIT = 4;

    // Prescaler masks: divide by 2, 4, 16, 256
    localparam logic [7:0] DIV2_MASK = 8'h01;
    localparam logic [7:0] DIV4_MASK = 8'h03;
    localparam logic [7:0] DIV16_MASK = 8'h0f;
    localparam logic [7:0] DIV256_MASK = 8'hff;

    // Latest clock at which a capture lands after its edge
    localparam int CAP_LAT_CYCLES = 2;

    typedef enum logic [1:0] {
        EDGE_OFF,
        EDGE_RISE,
        EDGE_FALL,
        EDGE_BOTH
    } frt_edge_e;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] cmp;
        logic [7:0] mode;
        logic [7:0] dir;
        logic [15:0] rbuf;
        logic held;
        logic [15:0] rdata;
        logic rvalid;
        logic irq;
    } frt_main_s;

    localparam frt_main_s MAIN_RST = '{
        cnt: RST_CNT,
        cmp: RST_CMP,
        mode: RST_MODE,
        dir: RST_DIR,
        rbuf: RST_CNT,
        held: 1'b0,
        rdata: 16'h0000,
        rvalid: 1'b0,
        irq: 1'b0
    };

    typedef struct packed {
        logic [7:0] div;
        logic tick;
    } frt_pre_s;

    typedef struct packed {
        logic pin_d;
        logic [15:0] value;
        logic loaded;
    } frt_cap_s;

endpackage : frt_pkg

// ==== tb/frt_trig_src.sv ====
// Trigger source model driving the capture pin with a chosen lag
`timescale 1ns/1ps
module frt_trig_src (
    // Clock
    input wire logic clk,
    // Requested level and lag in cycles
    input wire logic lvl,
    input wire logic [3:0] lag,
    // Trigger pin
    output logic pin
);
    logic [3:0] cnt = 4'h0;
    logic pin_q = 1'b0;

    assign pin = pin_q;

    // Level reaches the pin after the lag, then stays
    always @(posedge clk)
    begin
        if (lvl == pin_q)
            cnt <= 4'h0;
        else if (cnt >= lag)
        begin
            pin_q <= lvl;
            cnt <= 4'h0;
        end
        else
            cnt <= cnt + 4'h1;
    end
endmodule : frt_trig_src

// ==== tb/tb_top.sv ====
// Self-checking bench for the free-running timer
`timescale 1ns/1ps
module tb_top;
    logic SYS_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic WR_EN = 1'b0;
    logic RD_EN = 1'b0;
    logic WIDE = 1'b0;
    logic [15:0] ADDR = 16'h0000;
    logic [15:0] WDATA = 16'h0000;
    logic [7:0] WMASK = 8'h00;
    logic [15:0] RDATA;
    logic RVALID;
    logic CAPTURE_PIN;
    logic COMPARE_IRQ;
    logic [7:0] PORT2_OE_N;
    logic trig_lvl = 1'b0;
    logic [3:0] trig_lag = 4'h0;
    int error_cnt = 0;
    int n_checks = 0;

    always #2.5 SYS_CLK = ~SYS_CLK;

    frt_timer i_frt_timer (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR),
        .WR_EN(WR_EN), .RD_EN(RD_EN), .WIDE(WIDE), .WDATA(WDATA),
        .WMASK(WMASK), .RDATA(RDATA), .RVALID(RVALID),
        .CAPTURE_PIN(CAPTURE_PIN), .COMPARE_IRQ(COMPARE_IRQ),
        .PORT2_OE_N(PORT2_OE_N));

    frt_trig_src i_frt_trig_src (.clk(SYS_CLK), .lvl(trig_lvl),
        .lag(trig_lag), .pin(CAPTURE_PIN));

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rng(input logic [15:0] v, input logic [15:0] lo,
        input logic [15:0] hi);
        chk({15'h0000, v >= lo && v <= hi}, 16'h0001);
    endtask : rng

    task automatic step(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : step

    task automatic wr(input logic [15:0] a, input logic w,
        input logic [15:0] d, input logic [7:0] m);
        ADDR = a;
        WIDE = w;
        WDATA = d;
        WMASK = m;
        WR_EN = 1'b1;
        step(1);
        WR_EN = 1'b0;
        step(1);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic w,
        output logic [15:0] d);
        int i;
        ADDR = a;
        WIDE = w;
        RD_EN = 1'b1;
        step(1);
        RD_EN = 1'b0;
        for (i = 0; i < 4 && RVALID !== 1'b1; i++)
            step(1);
        if (RVALID !== 1'b1)
        begin
            error_cnt++;
            $display("mismatch at %0t: read not answered", $time);
            complete_run();
        end
        else
        begin
            d = RDATA;
            step(1);
        end
    endtask : rd

    task automatic t_reset();
        logic [15:0] v;
        rd(frt_pkg::ADDR_CMP, 1'b1, v);
        chk(v, 16'hffff);
        rd(frt_pkg::ADDR_MODE, 1'b0, v);
        chk(v, 16'h0000);
        rd(frt_pkg::ADDR_DIR, 1'b0, v);
        chk(v, 16'h00ff);
        chk({8'h00, PORT2_OE_N}, 16'h00ff);
        rd(frt_pkg::ADDR_CNT, 1'b1, v);
        rng(v, 16'h0001, 16'h0020);
        rd(16'hff30, 1'b1, v);
        chk(v, 16'h0000);
    endtask : t_reset

    task automatic t_regs();
        logic [15:0] v;
        wr(frt_pkg::ADDR_CMP + 16'h0001, 1'b0, 16'h0012, 8'hff);
        wr(frt_pkg::ADDR_CMP, 1'b0, 16'h0034, 8'hff);
        wr(frt_pkg::ADDR_CMP + 16'h0001, 1'b1, 16'hbeef, 8'hff);
        rd(frt_pkg::ADDR_CMP, 1'b1, v);
        chk(v, 16'h1234);
        rd(frt_pkg::ADDR_CMP + 16'h0001, 1'b0, v);
        chk(v, 16'h0012);
        // Fixed mode bits written as zero
        wr(frt_pkg::ADDR_MODE, 1'b0, 16'h0076, 8'hff);
        rd(frt_pkg::ADDR_MODE, 1'b0, v);
        chk(v, 16'h0036);
        wr(frt_pkg::ADDR_MODE, 1'b0, 16'h0000, 8'h02);
        rd(frt_pkg::ADDR_MODE, 1'b0, v);
        chk(v, 16'h0034);
        wr(frt_pkg::ADDR_MODE, 1'b0, 16'h0000, 8'hff);
        wr(frt_pkg::ADDR_DIR, 1'b0, 16'h00a5, 8'hff);
        chk({8'h00, PORT2_OE_N}, 16'h00a5);
        wr(frt_pkg::ADDR_DIR, 1'b0, 16'h00ff, 8'h5a);
        rd(frt_pkg::ADDR_DIR, 1'b0, v);
        chk(v, 16'h00ff);
    endtask : t_regs

    task automatic t_rate();
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] e;
        int sh[4] = '{1, 2, 4, 8};
        int s;
        for (s = 0; s < 4; s++)
        begin
            wr(frt_pkg::ADDR_MODE, 1'b0, 16'(s << 1), 8'hff);
            rd(frt_pkg::ADDR_CNT, 1'b1, a);
            step(512);
            rd(frt_pkg::ADDR_CNT, 1'b1, b);
            e = 16'(512 >> sh[s]);
            // Bus reads at full clock rate
            rng(b - a, e - 16'h0001, e + 16'h0003);
        end
    endtask : t_rate

    task automatic t_cmp();
        logic [15:0] a;
        logic [15:0] t;
        int i;
        int n;
        wr(frt_pkg::ADDR_MODE, 1'b0, 16'h0000, 8'hff);
        rd(frt_pkg::ADDR_CNT, 1'b1, a);
        t = a + 16'h0040;
        wr(frt_pkg::ADDR_CMP, 1'b1, t, 8'h00);
        chk({15'h0000, COMPARE_IRQ}, 16'h0000);
        for (i = 0; i < 400 && COMPARE_IRQ !== 1'b1; i++)
            step(1);
        chk({15'h0000, COMPARE_IRQ}, 16'h0001);
        if (COMPARE_IRQ !== 1'b1)
            complete_run();
        else
        begin
            for (n = 0; n < 8 && COMPARE_IRQ === 1'b1; n++)
                step(1);
            chk(16'(n), 16'h0002);
            rd(frt_pkg::ADDR_CNT, 1'b1, a);
            rng(a - t, 16'h0001, 16'h0004);
        end
    endtask : t_cmp

    task automatic t_pair();
        logic [15:0] l;
        logic [15:0] h;
        logic [15:0] w;
        rd(frt_pkg::ADDR_CNT, 1'b0, l);
        chk(l & 16'hff00, 16'h0000);
        step(600);
        rd(frt_pkg::ADDR_CNT + 16'h0001, 1'b0, h);
        rd(frt_pkg::ADDR_CNT, 1'b1, w);
        rng(w - {h[7:0], l[7:0]}, 16'd299, 16'd306);
    endtask : t_pair

    task automatic t_cap();
        logic [15:0] c0;
        logic [15:0] c1;
        logic [15:0] c2;
        logic [15:0] w;
        int k;
        wr(frt_pkg::ADDR_DIR, 1'b0, 16'h0010, 8'h10);
        for (k = 0; k < 5; k++)
        begin
            wr(frt_pkg::ADDR_MODE, 1'b0, 16'((k == 4 ? 3 : k) << 4), 8'hff);
            if (k == 4)
            begin
                // Trigger pin turned to output: no captures
                wr(frt_pkg::ADDR_DIR, 1'b0, 16'h0000, 8'h10);
                chk({8'h00, PORT2_OE_N}, 16'h00ef);
            end
            trig_lag = 4'(k);
            step(20);
            rd(frt_pkg::ADDR_CAP, 1'b1, c0);
            trig_lvl = 1'b1;
            step(20);
            rd(frt_pkg::ADDR_CAP, 1'b1, c1);
            rd(frt_pkg::ADDR_CNT, 1'b1, w);
            chk({15'h0000, c1 !== c0},
                {15'h0000, k == 1 || k == 3});
            if (c1 !== c0)
                rng(w - c1, 16'h0005, 16'h000f);
            trig_lvl = 1'b0;
            step(20);
            rd(frt_pkg::ADDR_CAP, 1'b1, c2);
            chk({15'h0000, c2 !== c1},
                {15'h0000, k == 2 || k == 3});
        end
        wr(frt_pkg::ADDR_DIR, 1'b0, 16'h00ff, 8'h10);
        step(20);
        rd(frt_pkg::ADDR_CAP, 1'b1, c0);
        chk(c0, c2);
    endtask : t_cap

    initial
    begin
        step(20);
        RESETN = 1'b1;
        step(3);
        t_reset();
        t_regs();
        t_rate();
        t_cmp();
        t_pair();
        t_cap();
        complete_run();
    end
endmodule : tb_top
